// ==== rtc_port_cfg.svh ====
// constants of the rtc serial register port
`ifndef RTC_PORT_CFG_SVH
`define RTC_PORT_CFG_SVH

// ==========================================================================
// byte framing
// ==========================================================================
`define RTC_BYTE_W 8
`define RTC_BIT_LAST 3'h7
`define RTC_BIT_RST 3'h0
`define RTC_DIR_BIT 7
`define RTC_BYTE_RST 8'h00

// ==========================================================================
// address wrap
// ==========================================================================
`define RTC_RD_WRAP_BASE 8'h00
`define RTC_WR_WRAP_BASE 8'h80
`define RTC_WRAP_NIBBLE 4'hF
`define RTC_REG_DEPTH 16
`define RTC_IDX_W 4

// ==========================================================================
// time snapshot
// ==========================================================================
`define RTC_TIME_BYTES 8
`define RTC_TIME_W 64

// ==========================================================================
// link timing
// ==========================================================================
`define RTC_SYNC_W 4
`define RTC_SCLK_PERIOD_NS 80

`endif

// ==== rtc_port_pkg.sv ====
// types of the rtc serial register port
package rtc_port_pkg;

    // ======================================================================
    // transfer states
    // ======================================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h4
    } port_state_t;

    typedef logic [7:0] byte_t;

endpackage : rtc_port_pkg

// ==== rtc_port_sync.sv ====
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rtc_port_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // ======================================================================
    // two stages, first stage read only by the second
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : rtc_port_sync

// ==== rtc_port_regfile.sv ====
// host-visible register copy with time snapshot load
`timescale 1ns/1ps
`include "rtc_port_cfg.svh"
module rtc_port_regfile (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic snap_in,
    input wire logic [`RTC_TIME_W-1:0] time_in,
    input wire logic wr_en_in,
    input wire logic [`RTC_IDX_W-1:0] wr_idx_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    input wire logic [`RTC_IDX_W-1:0] rd_idx_in,
    output logic [7:0] rd_data_out
);

    logic [7:0] mem_ff [`RTC_REG_DEPTH];
    logic [7:0] rd_data_ff;

    // ======================================================================
    // storage: snapshot loads the time bytes, host writes any byte
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < `RTC_REG_DEPTH; i++) begin
                mem_ff[i] <= `RTC_BYTE_RST;
            end
        end else if (snap_in) begin
            for (int i = 0; i < `RTC_TIME_BYTES; i++) begin
                mem_ff[i] <= time_in[i*8 +: 8];
            end
        end else if (wr_en_in) begin
            mem_ff[wr_idx_in] <= wr_data_in;
        end
    end

    // ======================================================================
    // registered read port
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            rd_data_ff <= `RTC_BYTE_RST;
        end else if (rd_en_in) begin
            rd_data_ff <= mem_ff[rd_idx_in];
        end
    end

    assign rd_data_out = rd_data_ff;

endmodule : rtc_port_regfile

// ==== rtc_serial_register_port.sv ====
// serial slave port of the clock register file, 4-wire or 3-wire variant
//
// Contract
// - 4-wire port works in modes 1/3 or modes 0/2, chosen at build time.
// - 4-wire select low opens a transfer, high ends it and mutes serial activity.
// - 4-wire port samples input on the sampling edge, changes output on the other.
// - one sclk cycle per bit, address and data move in eight-bit groups.
// - 4-wire bytes travel most significant bit first, both directions.
// - 4-wire read data leaves on the output line, write data enters on the input line.
// - first byte is the address; its top bit 0 means read, 1 means write.
// - address increments after each data byte for as long as the transfer lasts.
// - reads wrap 0Fh to 00h, writes wrap 8Fh to 80h.
// - 4-wire time copy refreshes when select falls, and once on reset release while the synchroniser still holds select low.
// - 3-wire port shares one pin, turning it around after the address for reads.
// - 3-wire port samples on rising sclk, presents output after falling sclk.
// - 3-wire bytes travel least significant bit first, both directions.
// - 3-wire enable rise opens a transfer with the address byte, fall ends it.
// - 3-wire time copy refreshes only on the enable rise.
// - 4-wire output floats while deselected and until a full read byte is ready.
`timescale 1ns/1ps
`include "rtc_port_cfg.svh"
module rtc_serial_register_port #(
    parameter bit FOUR_WIRE = 1'b1,
    parameter bit CPHA = 1'b1
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic sclk_in,
    input wire logic select_in,
    input wire logic serial_in_pin_in,
    output logic serial_out_pin_out,
    output logic serial_out_pin_oe_out,
    input wire logic io_pin_in,
    output logic io_pin_out,
    output logic io_pin_oe_out,
    input wire logic [`RTC_TIME_W-1:0] time_live_in,
    output logic wr_strobe_out,
    output logic [7:0] wr_addr_out,
    output logic [7:0] wr_data_out,
    output logic busy_out
);

    // ======================================================================
    // pin synchronisation
    // ======================================================================
    logic [`RTC_SYNC_W-1:0] pins_sync;
    wire sclk_s = pins_sync[0];
    wire select_s = pins_sync[1];
    wire din_s = pins_sync[2];
    wire io_s = pins_sync[3];

    rtc_port_sync #(
        .WIDTH(`RTC_SYNC_W)
    ) u_sync (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .async_in({io_pin_in, serial_in_pin_in, select_in, sclk_in}),
        .sync_out(pins_sync)
    );

    // ======================================================================
    // registers
    // ======================================================================
    rtc_port_pkg::port_state_t state_ff;
    rtc_port_pkg::port_state_t nxt_state;
    logic sclk_d_ff;
    logic act_d_ff;
    logic cpol_ff;
    logic [2:0] bit_cnt_ff;
    rtc_port_pkg::byte_t rx_ff;
    rtc_port_pkg::byte_t addr_ff;
    logic write_ff;
    rtc_port_pkg::byte_t tx_sh_ff;
    logic tx_valid_ff;
    logic rd_req_ff;
    logic load_ff;
    logic snap_ff;
    logic out_ff;
    logic oe_ff;
    logic wr_strobe_ff;
    rtc_port_pkg::byte_t wr_addr_ff;
    rtc_port_pkg::byte_t wr_data_ff;
    rtc_port_pkg::byte_t rd_data;

    // ======================================================================
    // transfer framing and edge decode
    // ======================================================================
    // select polarity follows the variant
    wire sel_act = FOUR_WIRE ? ~select_s : select_s;
    wire start = sel_act & ~act_d_ff;
    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;
    // edge returning sclk to its idle level, and edge leaving it
    wire to_idle = cpol_ff ? sclk_rise : sclk_fall;
    wire from_idle = cpol_ff ? sclk_fall : sclk_rise;
    wire spi_sample = CPHA ? to_idle : from_idle;
    wire spi_shift = CPHA ? from_idle : to_idle;
    wire sample_edge = FOUR_WIRE ? spi_sample : sclk_rise;
    wire shift_edge = FOUR_WIRE ? spi_shift : sclk_fall;
    wire in_frame = sel_act & (state_ff != rtc_port_pkg::ST_IDLE);
    wire bit_in = FOUR_WIRE ? din_s : io_s;
    wire sample = in_frame & sample_edge;
    wire byte_done = sample & (bit_cnt_ff == `RTC_BIT_LAST);

    // ======================================================================
    // bit order and address step
    // ======================================================================
    wire [7:0] rx_next = FOUR_WIRE ? {rx_ff[6:0], bit_in} : {bit_in, rx_ff[7:1]};
    wire tx_bit = FOUR_WIRE ? tx_sh_ff[7] : tx_sh_ff[0];
    wire [7:0] tx_next = FOUR_WIRE ? {tx_sh_ff[6:0], 1'b0} : {1'b0, tx_sh_ff[7:1]};
    wire [7:0] wrap_base = write_ff ? `RTC_WR_WRAP_BASE : `RTC_RD_WRAP_BASE;
    wire at_wrap = addr_ff[3:0] == `RTC_WRAP_NIBBLE;
    wire [7:0] addr_inc = at_wrap ? wrap_base : 8'(addr_ff + 8'h01);
    wire addr_byte = byte_done & (state_ff == rtc_port_pkg::ST_ADDR);
    wire data_byte = byte_done & (state_ff == rtc_port_pkg::ST_DATA);
    wire wr_byte = data_byte & write_ff;
    wire is_read = ~rx_next[`RTC_DIR_BIT];
    wire drive_bit = in_frame & shift_edge & tx_valid_ff & ~write_ff;

    // ======================================================================
    // state machine
    // ======================================================================
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rtc_port_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_state = rtc_port_pkg::ST_ADDR;
                end
            end
            rtc_port_pkg::ST_ADDR: begin
                if (!sel_act) begin
                    nxt_state = rtc_port_pkg::ST_IDLE;
                end else if (byte_done) begin
                    nxt_state = rtc_port_pkg::ST_DATA;
                end
            end
            rtc_port_pkg::ST_DATA: begin
                if (!sel_act) begin
                    nxt_state = rtc_port_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_state = rtc_port_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_ff <= rtc_port_pkg::ST_IDLE;
            sclk_d_ff <= 1'b0;
            act_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sclk_d_ff <= sclk_s;
            act_d_ff <= sel_act;
        end
    end

    // ======================================================================
    // idle clock level caught at transfer start
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            cpol_ff <= 1'b0;
        end else if (start) begin
            cpol_ff <= sclk_s;
        end
    end

    // ======================================================================
    // receive shifter
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in || !in_frame) begin
            bit_cnt_ff <= `RTC_BIT_RST;
            rx_ff <= `RTC_BYTE_RST;
        end else if (sample) begin
            bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
            rx_ff <= rx_next;
        end
    end

    // ======================================================================
    // address and direction
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            addr_ff <= `RTC_BYTE_RST;
            write_ff <= 1'b0;
        end else if (addr_byte) begin
            addr_ff <= rx_next;
            write_ff <= rx_next[`RTC_DIR_BIT];
        end else if (wr_byte || load_ff) begin
            addr_ff <= addr_inc;
        end
    end

    // ======================================================================
    // read prefetch: request, then load one cycle after the memory read
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            rd_req_ff <= 1'b0;
            load_ff <= 1'b0;
        end else begin
            rd_req_ff <= (addr_byte & is_read) | (data_byte & ~write_ff);
            load_ff <= rd_req_ff & sel_act;
        end
    end

    // ======================================================================
    // transmit shifter and pin drive
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in || !sel_act) begin
            tx_sh_ff <= `RTC_BYTE_RST;
            tx_valid_ff <= 1'b0;
        end else if (load_ff) begin
            tx_sh_ff <= rd_data;
            tx_valid_ff <= 1'b1;
        end else if (drive_bit) begin
            tx_sh_ff <= tx_next;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in || !sel_act) begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (drive_bit) begin
            out_ff <= tx_bit;
            oe_ff <= 1'b1;
        end
    end

    // ======================================================================
    // snapshot at transfer start
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            snap_ff <= 1'b0;
        end else begin
            snap_ff <= start;
        end
    end

    // ======================================================================
    // write strobe towards the clock core
    // ======================================================================
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            wr_strobe_ff <= 1'b0;
            wr_addr_ff <= `RTC_BYTE_RST;
            wr_data_ff <= `RTC_BYTE_RST;
        end else begin
            wr_strobe_ff <= wr_byte;
            if (wr_byte) begin
                wr_addr_ff <= addr_ff;
                wr_data_ff <= rx_next;
            end
        end
    end

    // ======================================================================
    // register copy
    // ======================================================================
    rtc_port_regfile u_regfile (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .snap_in(snap_ff),
        .time_in(time_live_in),
        .wr_en_in(wr_strobe_ff),
        .wr_idx_in(wr_addr_ff[3:0]),
        .wr_data_in(wr_data_ff),
        .rd_en_in(rd_req_ff),
        .rd_idx_in(addr_ff[3:0]),
        .rd_data_out(rd_data)
    );

    // ======================================================================
    // outputs: the pin of the unused variant stays released
    // ======================================================================
    assign serial_out_pin_out = FOUR_WIRE ? out_ff : 1'b0;
    assign serial_out_pin_oe_out = FOUR_WIRE ? oe_ff : 1'b0;
    assign io_pin_out = FOUR_WIRE ? 1'b0 : out_ff;
    assign io_pin_oe_out = FOUR_WIRE ? 1'b0 : oe_ff;
    assign wr_strobe_out = wr_strobe_ff;
    assign wr_addr_out = wr_addr_ff;
    assign wr_data_out = wr_data_ff;
    assign busy_out = act_d_ff;

endmodule : rtc_serial_register_port

// ==== rtc_port_checker.sv ====
// assertion checker for the rtc serial register port
`timescale 1ns/1ps
module rtc_port_checker #(
    parameter bit FOUR_WIRE = 1'b1,
    parameter bit CPHA = 1'b1
) (
    input wire logic clock_in,
    input wire logic reset_n_in,
    input wire logic sclk_in,
    input wire logic select_in,
    input wire logic serial_out_pin_out,
    input wire logic serial_out_pin_oe_out,
    input wire logic io_pin_out,
    input wire logic io_pin_oe_out,
    input wire logic wr_strobe_out,
    input wire logic [7:0] wr_addr_out,
    input wire logic busy_out
);
    // ==================================================================
    // previous write address within one transfer
    // ==================================================================
    logic [7:0] last_addr_ff;
    logic have_addr_ff;
    logic [7:0] nxt_addr;
    assign nxt_addr = {4'h8, last_addr_ff[3:0] + 4'h1};
    always_ff @(posedge clock_in) begin
        if (!reset_n_in || !busy_out) begin
            have_addr_ff <= 1'b0;
        end else if (wr_strobe_out) begin
            have_addr_ff <= 1'b1;
        end
    end
    always_ff @(posedge clock_in) begin
        if (wr_strobe_out) begin
            last_addr_ff <= wr_addr_out;
        end
    end

    // ==================================================================
    // assertions
    // ==================================================================
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);

    a_deselect_no_drive: assert property ((FOUR_WIRE && select_in) [*6] |->
        !serial_out_pin_oe_out) else $error("output driven while deselected");
    a_deselect_no_write: assert property ((FOUR_WIRE && select_in) [*8] |->
        !wr_strobe_out && !busy_out) else $error("activity while deselected");
    a_strobe_one_byte: assert property (wr_strobe_out |=> !wr_strobe_out [*8])
        else $error("write strobe too long or too close");
    a_write_dir_bit: assert property (wr_strobe_out |->
        wr_addr_out[7] && busy_out && !serial_out_pin_oe_out) else $error("bad write");
    a_addr_increment: assert property (wr_strobe_out && have_addr_ff |->
        wr_addr_out == nxt_addr) else $error("write address did not step");
    a_shift_after_edge: assert property (serial_out_pin_oe_out && $past(serial_out_pin_oe_out)
        && $changed(serial_out_pin_out) |-> $past(sclk_in, 2) != $past(sclk_in, 5))
        else $error("output changed without a clock edge");
    a_select_opens: assert property (FOUR_WIRE && $fell(select_in) |-> ##[1:4] busy_out)
        else $error("transfer did not open");
    a_select_closes: assert property (FOUR_WIRE && $rose(select_in) |->
        ##[1:5] (!busy_out && !serial_out_pin_oe_out)) else $error("transfer did not close");
    a_oe_in_frame: assert property ($rose(serial_out_pin_oe_out) |->
        busy_out && !select_in) else $error("output enabled outside a transfer");
    a_unused_quiet: assert property (FOUR_WIRE |-> !io_pin_oe_out && !io_pin_out)
        else $error("shared pin active in 4-wire build");
endmodule : rtc_port_checker

bind rtc_serial_register_port rtc_port_checker #(
    .FOUR_WIRE(FOUR_WIRE),
    .CPHA(CPHA)
) u_checker (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .sclk_in(sclk_in),
    .select_in(select_in),
    .serial_out_pin_out(serial_out_pin_out),
    .serial_out_pin_oe_out(serial_out_pin_oe_out),
    .io_pin_out(io_pin_out),
    .io_pin_oe_out(io_pin_oe_out),
    .wr_strobe_out(wr_strobe_out),
    .wr_addr_out(wr_addr_out),
    .busy_out(busy_out)
);

// ==== rtc_host_model.sv ====
// host serial master model in clock mode 3
`timescale 1ns/1ps
module rtc_host_model (
    input wire logic clock_in,
    input wire logic miso_in,
    input wire logic miso_oe_in,
    output logic sclk_out,
    output logic select_n_out,
    output logic mosi_out
);
    initial begin
        sclk_out = 1'b1;
        select_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    task automatic frame_begin;
        @(posedge clock_in);
        select_n_out <= 1'b0;
        repeat (4) @(posedge clock_in);
    endtask : frame_begin

    // shift on the falling edge, sample on the rising edge, 80 ns per bit
    task automatic xfer_byte(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i >= 8 - nbits; i--) begin
            @(posedge clock_in);
            sclk_out <= 1'b0;
            mosi_out <= tx[i];
            repeat (5) @(posedge clock_in);
            sclk_out <= 1'b1;
            rx[i] = miso_oe_in ? miso_in : ~miso_in;
            repeat (4) @(posedge clock_in);
        end
    endtask : xfer_byte

    // released data line shows the inverse of its last level
    task automatic frame_end;
        @(posedge clock_in);
        select_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        repeat (10) @(posedge clock_in);
    endtask : frame_end
endmodule : rtc_host_model

// ==== testbench.sv ====
// self-checking testbench of the rtc serial register port
`timescale 1ns/1ps
`include "rtc_port_cfg.svh"
module testbench;
    localparam logic [63:0] TIME_A = 64'h8877665544332211;
    localparam logic [63:0] TIME_B = 64'hF0E1D2C3B4A59687;
    typedef struct {logic [7:0] addr; logic [7:0] data;} row_t;
    row_t rows[4] = '{'{8'h88, 8'h1E}, '{8'h8B, 8'hA7}, '{8'h8F, 8'hFF}, '{8'h8A, 8'h01}};
    logic clock_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [`RTC_TIME_W-1:0] time_live = TIME_A;
    logic sclk, select_n, mosi, miso, miso_oe, io_out, io_oe, wr_strobe, busy;
    logic [7:0] wr_addr, wr_data;
    logic io_out3, io_oe3, wr_strobe3, busy3;
    logic [7:0] wr_addr3, wr_data3;
    logic sel_3w = 1'b0;
    wire io3_in = io_oe3 ? io_out3 : mosi;
    wire miso_h = sel_3w ? io_out3 : miso;
    wire miso_oe_h = sel_3w ? io_oe3 : miso_oe;
    logic [15:0] wr_log[$];
    logic [7:0] q[$];
    int mismatches = 0;
    int compares = 0;

    always #4 clock_in = ~clock_in;

    rtc_serial_register_port #(.FOUR_WIRE(1'b1), .CPHA(1'b1)) u_dut (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .sclk_in(sclk), .select_in(select_n),
        .serial_in_pin_in(mosi), .serial_out_pin_out(miso), .serial_out_pin_oe_out(miso_oe),
        .io_pin_in(1'b0), .io_pin_out(io_out), .io_pin_oe_out(io_oe),
        .time_live_in(time_live), .wr_strobe_out(wr_strobe), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data), .busy_out(busy)
    );

    // 3-wire build on the same host lines, enable is the inverted select
    rtc_serial_register_port #(.FOUR_WIRE(1'b0), .CPHA(1'b1)) u_dut_3w (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .sclk_in(sclk), .select_in(~select_n),
        .serial_in_pin_in(1'b0), .serial_out_pin_out(), .serial_out_pin_oe_out(),
        .io_pin_in(io3_in), .io_pin_out(io_out3), .io_pin_oe_out(io_oe3),
        .time_live_in(time_live), .wr_strobe_out(wr_strobe3), .wr_addr_out(wr_addr3),
        .wr_data_out(wr_data3), .busy_out(busy3)
    );

    rtc_host_model u_host (
        .clock_in(clock_in), .miso_in(miso_h), .miso_oe_in(miso_oe_h),
        .sclk_out(sclk), .select_n_out(select_n), .mosi_out(mosi)
    );

    always @(posedge clock_in) begin
        if (wr_strobe === 1'b1) begin
            wr_log.push_back({wr_addr, wr_data});
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic expect_write(input logic [7:0] addr, input logic [7:0] data);
        logic [15:0] w;
        w = (wr_log.size() > 0) ? wr_log.pop_front() : 16'hXXXX;
        check(w[15:8], addr);
        check(w[7:0], data);
    endtask : expect_write

    // address byte, then data bytes; a read frame returns what it saw in data
    task automatic frame(input logic [7:0] addr, ref logic [7:0] data[$], input int last_bits);
        logic [7:0] rx;
        time_live <= TIME_A;
        u_host.frame_begin();
        u_host.xfer_byte(addr, 8, rx);
        for (int k = 0; k < data.size(); k++) begin
            u_host.xfer_byte(data[k], (k == data.size() - 1) ? last_bits : 8, rx);
            time_live <= TIME_B;
            data[k] = rx;
        end
        u_host.frame_end();
    endtask : frame

    task automatic test_done;
        if (mismatches == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        mismatches++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge clock_in);
        check({miso, miso_oe, wr_strobe, busy, io_oe, io_out, busy3, io_oe3}, 8'h00);
        check(wr_addr | wr_data, 8'h00);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        // ==============================================================
        // single-byte write then read back
        // ==============================================================
        foreach (rows[i]) begin
            q = '{rows[i].data};
            frame(rows[i].addr, q, 8);
            expect_write(rows[i].addr, rows[i].data);
            q = '{8'h00};
            frame(rows[i].addr & 8'h7F, q, 8);
            check(q[0], rows[i].data);
        end
        // ==============================================================
        // burst write across the write wrap
        // ==============================================================
        q = '{8'h11, 8'h22, 8'h33};
        frame(8'h8E, q, 8);
        expect_write(8'h8E, 8'h11);
        expect_write(8'h8F, 8'h22);
        expect_write(8'h80, 8'h33);
        // ==============================================================
        // burst read across the read wrap, time frozen at frame start
        // ==============================================================
        q = '{10{8'h00}};
        frame(8'h0E, q, 8);
        check(q[0], 8'h11);
        check(q[1], 8'h22);
        for (int k = 0; k < 8; k++) begin
            check(q[k + 2], TIME_A[8 * k +: 8]);
        end
        // ==============================================================
        // select released mid-byte drops the partial byte
        // ==============================================================
        q = '{8'h5A};
        frame(8'h89, q, 8);
        expect_write(8'h89, 8'h5A);
        q = '{8'hC3};
        frame(8'h89, q, 4);
        check(8'(wr_log.size()), 8'h00);
        q = '{8'h00};
        frame(8'h09, q, 8);
        check(q[0], 8'h5A);
        // ==============================================================
        // 3-wire build: host shifts msb first, so bytes go bit-reversed
        // ==============================================================
        sel_3w <= 1'b1;
        q = '{8'h78};
        frame(8'h91, q, 8);
        check(wr_addr3, 8'h89);
        check(wr_data3, 8'h1E);
        q = '{8'h00};
        frame(8'h90, q, 8);
        check(q[0], 8'h78);
        test_done();
    end
endmodule : testbench
